// ### rtl/twde_map.svh
`ifndef TWDE_MAP_SVH
`define TWDE_MAP_SVH

// Register offsets (byte addresses)
`define TWDE_OFF_CTRL      8'h00
`define TWDE_OFF_ADDR_PAT  8'h04
`define TWDE_OFF_DATA_PAT  8'h08
`define TWDE_OFF_DELAY     8'h0C
`define TWDE_OFF_STATUS    8'h10
`define TWDE_OFF_IRQ_STAT  8'h14
`define TWDE_OFF_IRQ_MASK  8'h18

// Control register fields
`define TWDE_CTRL_EDGE_FALL  0
`define TWDE_CTRL_CNT_SRC    1
`define TWDE_CTRL_AMODE_LO   2
`define TWDE_CTRL_Q0_LO      4
`define TWDE_CTRL_Q1_LO      6
`define TWDE_CTRL_VIEW_LO    8
`define TWDE_CTRL_REARM      31

// Data pattern fields: value in low byte, care mask in next byte
`define TWDE_DPAT_VAL_LO   0
`define TWDE_DPAT_CARE_LO  8

// Status register fields
`define TWDE_STAT_ARMED    0
`define TWDE_STAT_DELAYING 1
`define TWDE_STAT_DONE     2
`define TWDE_STAT_COUNT_LO 16

// Interrupt bits
`define TWDE_IRQ_TRIG      0
`define TWDE_IRQ_DONE      1

// Reset values
`define TWDE_RST_ADDR_PAT  16'h0000
`define TWDE_RST_DATA_VAL  8'h00
`define TWDE_RST_DATA_CARE 8'h00
`define TWDE_RST_DELAY     10'h000
`define TWDE_RST_IRQ_MASK  2'h0

// Delay range, decimal 0 to 999 events
`define TWDE_DELAY_MAX     10'h3E7

`endif

// ### rtl/twde_pkg.sv
package twde_pkg;

    typedef enum logic [1:0] {
        TWDE_AM_SYNC,
        TWDE_AM_OFF,
        TWDE_AM_ASYNC
    } twde_amode_t;

    typedef enum logic [1:0] {
        TWDE_Q_X,
        TWDE_Q_ONE,
        TWDE_Q_ZERO
    } twde_qsel_t;

    typedef enum logic [1:0] {
        TWDE_VIEW_DATA,
        TWDE_VIEW_ADDR_LO,
        TWDE_VIEW_ADDR_HI
    } twde_view_t;

    typedef enum logic [1:0] {
        TWDE_ARMED,
        TWDE_DELAYING,
        TWDE_DONE
    } twde_phase_t;

    // Lines from the system under test
    typedef struct packed {
        logic        clk;
        logic [15:0] addr;
        logic [7:0]  data;
        logic        addr_qual;
        logic        clk_qual;
    } twde_sut_t;

    // Path toward the host analyzer's capture memory
    typedef struct packed {
        logic [7:0] cap_byte;
        logic       cap_strobe;
        logic       capture_done;
    } twde_host_t;

    typedef struct packed {
        logic        edge_fall;
        logic        delay_count_source;
        twde_amode_t amode;
        twde_qsel_t  q0_sel;
        twde_qsel_t  q1_sel;
        twde_view_t  byte_view_select;
        logic [15:0] addr_pat;
        logic [7:0]  data_val;
        logic [7:0]  data_care;
        logic [9:0]  delay;
        logic [1:0]  irq_mask;
    } twde_cfg_t;

    typedef struct packed {
        twde_sut_t   sut_s1;
        twde_sut_t   sut_s2;
        logic        clk_prev;
        logic        host_rst_s1;
        logic        host_rst_s2;
        logic        hit_prev;
        twde_cfg_t   cfg;
        twde_phase_t phase;
        logic [9:0]  count;
        logic [1:0]  irq_stat;
        logic        irq;
        logic        match_pulse;
        logic        armed;
        twde_host_t  host;
        logic [31:0] rdata;
    } twde_state_t;

endpackage

// ### rtl/twde_top.sv
//Function
//- Compare sixteen address inputs with a sixteen-bit address pattern.
//- Match eight data bits each as one, zero or don't-care.
//- Trigger word is address match and data match together.
//- Sample inputs on rising or falling edge of the target clock.
//- Clock qualifier one/zero/don't-care gates which clock edges count.
//- Address qualifier one/zero/don't-care must agree for an address match.
//- Delay of 0 to 999 events before capture is released.
//- Delay counts qualified clocks or trigger words, by setting.
//- Address trigger modes: synchronous, off, asynchronous.
//- Pulse the trigger output whenever a valid trigger word is seen in synchronous and off modes.
//- Armed indicator high while waiting for trigger, low afterwards.
//- Byte selector routes high, low address or data byte to host.
//- Stand-alone word recognizer: sync pulse at match or after delay.
//- Synchronous mode samples address and qualifier on the active edge.
//- Off mode ignores address lines and address qualifier.
//- Asynchronous mode: level output from address and qualifier only.
//- Delay setting zero releases capture right at the trigger.
`timescale 1ns/1ps
`include "twde_map.svh"

module twde_top
    import twde_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        nrst,
    input  wire logic        clk_en,
    input  wire logic [7:0]  bus_addr,
    input  wire logic [31:0] bus_wdata,
    input  wire logic        bus_wr,
    input  wire logic        bus_rd,
    output logic      [31:0] bus_rdata,
    input  wire twde_sut_t   sut_in,
    input  wire logic        host_reset_req,
    output twde_host_t       host_out,
    output logic             match_pulse_out,
    output logic             armed_out,
    output logic             irq
);

    // Qualifier line is accepted when it agrees with the 3-way setting
    function automatic logic qual_ok(input twde_qsel_t sel, input logic v);
        unique case (sel)
            TWDE_Q_X:    qual_ok = 1'b1;
            TWDE_Q_ONE:  qual_ok = v;
            TWDE_Q_ZERO: qual_ok = !v;
            default:     qual_ok = 1'b1;
        endcase
    endfunction

    function automatic twde_state_t reset_state();
        twde_state_t s;
        s                        = '0;
        s.cfg.amode              = TWDE_AM_SYNC;
        s.cfg.q0_sel             = TWDE_Q_X;
        s.cfg.q1_sel             = TWDE_Q_X;
        s.cfg.byte_view_select   = TWDE_VIEW_DATA;
        s.cfg.addr_pat           = `TWDE_RST_ADDR_PAT;
        s.cfg.data_val           = `TWDE_RST_DATA_VAL;
        s.cfg.data_care          = `TWDE_RST_DATA_CARE;
        s.cfg.delay              = `TWDE_RST_DELAY;
        s.cfg.irq_mask           = `TWDE_RST_IRQ_MASK;
        s.phase                  = TWDE_ARMED;
        s.armed                  = 1'b1;
        reset_state              = s;
    endfunction

    // Reset image built once, so the reset branch only loads a constant
    localparam twde_state_t RST_STATE = reset_state();

    // one of three bytes toward the capture memory
    // Code 3 shows the data byte rather than a stale value
    function automatic logic [7:0] view_byte(input twde_view_t sel,
                                             input twde_sut_t  s);
        unique case (sel)
            TWDE_VIEW_ADDR_LO: view_byte = s.addr[7:0];
            TWDE_VIEW_ADDR_HI: view_byte = s.addr[15:8];
            default:           view_byte = s.data;
        endcase
    endfunction

    // Phase flags are one-hot so software can test a single bit
    // Count is the live value, zero outside the delay phase
    function automatic logic [31:0] status_word(input twde_state_t s);
        status_word                            = 32'h0000_0000;
        status_word[`TWDE_STAT_ARMED]          = (s.phase == TWDE_ARMED);
        status_word[`TWDE_STAT_DELAYING]       = (s.phase == TWDE_DELAYING);
        status_word[`TWDE_STAT_DONE]           = (s.phase == TWDE_DONE);
        status_word[`TWDE_STAT_COUNT_LO +: 10] = s.count;
    endfunction

    // values past 999 saturate to keep the decimal range
    function automatic logic [9:0] clip_delay(input logic [9:0] v);
        if (v > `TWDE_DELAY_MAX) begin
            clip_delay = `TWDE_DELAY_MAX;
        end else begin
            clip_delay = v;
        end
    endfunction

    twde_state_t r;
    twde_state_t next_r;

    // Per-bit compare results, reduced further down
    logic [7:0]  data_bit_ok;
    logic [15:0] addr_bit_ok;

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_dbit
            assign data_bit_ok[gi] = !r.cfg.data_care[gi]
                || (r.sut_s2.data[gi] == r.cfg.data_val[gi]);
        end
    endgenerate

    generate
        for (gi = 0; gi < 16; gi++) begin : g_abit
            assign addr_bit_ok[gi] =
                (r.sut_s2.addr[gi] == r.cfg.addr_pat[gi]);
        end
    endgenerate

    logic        act_edge;
    logic        rise_seen;
    logic        fall_seen;
    logic        cq_ok;
    logic        aq_ok;
    logic        async_md;

    logic        qclk;
    logic        addr_hit;
    logic        data_hit;
    logic        word_hit;
    logic        trig_evt;
    logic        cnt_evt;
    logic        rearm;
    logic        release_now;
    logic [1:0]  irq_set;
    logic [1:0]  irq_clr;
    logic [31:0] rd_val;

    always_comb begin
        next_r = r;

        // Two-stage synchronisers; stage one feeds stage two only
        // The target lines are not on this clock: nothing but stage two reads stage one
        next_r.sut_s1      = sut_in;
        next_r.sut_s2      = r.sut_s1;
        next_r.clk_prev    = r.sut_s2.clk;
        next_r.host_rst_s1 = host_reset_req;
        next_r.host_rst_s2 = r.host_rst_s1;

        // active edge select
        // Edges come from the synchronised copy: three clocks of latency
        // are traded for never reading a metastable target clock
        rise_seen = r.sut_s2.clk && !r.clk_prev;
        fall_seen = !r.sut_s2.clk && r.clk_prev;
        act_edge  = r.cfg.edge_fall ? fall_seen : rise_seen;

        cq_ok = qual_ok(r.cfg.q1_sel, r.sut_s2.clk_qual);
        qclk  = act_edge && cq_ok;

        aq_ok = qual_ok(r.cfg.q0_sel, r.sut_s2.addr_qual);

        addr_hit = (&addr_bit_ok) && aq_ok;
        data_hit = &data_bit_ok;
        // Async mode drops the data byte and the target clock
        async_md = (r.cfg.amode == TWDE_AM_ASYNC);

        // address trigger mode selects the word
        unique case (r.cfg.amode)
            TWDE_AM_OFF: word_hit = data_hit;
            // level from address and qualifier only
            TWDE_AM_ASYNC: word_hit = addr_hit;
            default: word_hit = addr_hit && data_hit;
        endcase

        // Async mode ignores the target clock; one event per rising level
        if (async_md) begin
            trig_evt = word_hit && !r.hit_prev;
        end else begin
            // sampled at the qualified active edge
            trig_evt = qclk && word_hit;
        end
        next_r.hit_prev = word_hit;

        // trigger output, level in async mode
        next_r.match_pulse = async_md ? word_hit : trig_evt;

        cnt_evt = r.cfg.delay_count_source ? trig_evt : qclk;

        // byte routed toward capture memory on each qualified edge
        next_r.host.cap_strobe = qclk;
        // Byte holds between qualified edges so the host may take it late
        if (qclk) begin
            next_r.host.cap_byte = view_byte(r.cfg.byte_view_select,
                                             r.sut_s2);
        end

        // re-arm from software or the host line
        rearm = r.host_rst_s2
            || (bus_wr && bus_addr == `TWDE_OFF_CTRL
                && bus_wdata[`TWDE_CTRL_REARM]);

        release_now = 1'b0;
        unique case (r.phase)
            TWDE_ARMED: begin
                if (trig_evt) begin
                    if (r.cfg.delay == 10'h000) begin
                        release_now  = 1'b1;
                        next_r.phase = TWDE_DONE;
                    end else begin
                        next_r.count = r.cfg.delay;
                        next_r.phase = TWDE_DELAYING;
                    end
                end
            end
            TWDE_DELAYING: begin
                if (cnt_evt) begin
                    next_r.count = r.count - 10'h001;
                    if (r.count == 10'h001) begin
                        release_now  = 1'b1;
                        next_r.phase = TWDE_DONE;
                    end
                end
            end
            TWDE_DONE: begin
                next_r.count = 10'h000;
            end

            // An upset phase code falls back to waiting for a trigger
            default: begin
                next_r.phase = TWDE_ARMED;
                next_r.count = 10'h000;
            end
        endcase

        // Re-arm outranks a trigger or a release in the same cycle
        if (rearm) begin
            next_r.phase = TWDE_ARMED;
            next_r.count = 10'h000;
            release_now  = 1'b0;
        end
        next_r.host.capture_done = release_now;
        next_r.armed = (next_r.phase == TWDE_ARMED);

        // Register writes; read-only or unmapped offsets drop the data
        irq_clr = 2'h0;
        if (bus_wr) begin
            unique case (bus_addr)
                `TWDE_OFF_CTRL: begin
                    next_r.cfg.edge_fall = bus_wdata[`TWDE_CTRL_EDGE_FALL];
                    next_r.cfg.delay_count_source =
                        bus_wdata[`TWDE_CTRL_CNT_SRC];
                    next_r.cfg.amode = twde_amode_t'(
                        bus_wdata[`TWDE_CTRL_AMODE_LO +: 2]);
                    next_r.cfg.q0_sel = twde_qsel_t'(
                        bus_wdata[`TWDE_CTRL_Q0_LO +: 2]);
                    next_r.cfg.q1_sel = twde_qsel_t'(
                        bus_wdata[`TWDE_CTRL_Q1_LO +: 2]);
                    next_r.cfg.byte_view_select = twde_view_t'(
                        bus_wdata[`TWDE_CTRL_VIEW_LO +: 2]);
                end
                `TWDE_OFF_ADDR_PAT: next_r.cfg.addr_pat = bus_wdata[15:0];
                `TWDE_OFF_DATA_PAT: begin
                    next_r.cfg.data_val  = bus_wdata[`TWDE_DPAT_VAL_LO +: 8];
                    next_r.cfg.data_care = bus_wdata[`TWDE_DPAT_CARE_LO +: 8];
                end

                `TWDE_OFF_DELAY:
                    next_r.cfg.delay = clip_delay(bus_wdata[9:0]);

                `TWDE_OFF_IRQ_STAT: irq_clr = bus_wdata[1:0];
                `TWDE_OFF_IRQ_MASK: next_r.cfg.irq_mask = bus_wdata[1:0];
                default: ;
            endcase
        end

        // Sticky events; a set in the clearing cycle survives
        irq_set = 2'h0;
        irq_set[`TWDE_IRQ_TRIG] = trig_evt && (r.phase == TWDE_ARMED);
        irq_set[`TWDE_IRQ_DONE] = release_now;
        next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
        next_r.irq      = |(next_r.irq_stat & r.cfg.irq_mask);

        // Read data stands only in the cycle after the strobe
        // Unmapped offsets read as zero
        rd_val = 32'h0000_0000;
        unique case (bus_addr)
            `TWDE_OFF_CTRL: begin
                rd_val[`TWDE_CTRL_EDGE_FALL]   = r.cfg.edge_fall;
                rd_val[`TWDE_CTRL_CNT_SRC]     = r.cfg.delay_count_source;
                rd_val[`TWDE_CTRL_AMODE_LO +: 2] = r.cfg.amode;
                rd_val[`TWDE_CTRL_Q0_LO +: 2]  = r.cfg.q0_sel;
                rd_val[`TWDE_CTRL_Q1_LO +: 2]  = r.cfg.q1_sel;
                rd_val[`TWDE_CTRL_VIEW_LO +: 2] = r.cfg.byte_view_select;
            end
            `TWDE_OFF_ADDR_PAT: rd_val[15:0] = r.cfg.addr_pat;
            `TWDE_OFF_DATA_PAT: begin
                rd_val[`TWDE_DPAT_VAL_LO +: 8]  = r.cfg.data_val;
                rd_val[`TWDE_DPAT_CARE_LO +: 8] = r.cfg.data_care;
            end
            `TWDE_OFF_DELAY: rd_val[9:0] = r.cfg.delay;

            `TWDE_OFF_STATUS: rd_val = status_word(r);

            `TWDE_OFF_IRQ_STAT: rd_val[1:0] = r.irq_stat;
            `TWDE_OFF_IRQ_MASK: rd_val[1:0] = r.cfg.irq_mask;
            default: ;
        endcase
        next_r.rdata = bus_rd ? rd_val : 32'h0000_0000;
    end

    // Clock enable low freezes everything, bus accesses included
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            r <= RST_STATE;
        end else if (clk_en) begin
            r <= next_r;
        end
    end

    assign bus_rdata       = r.rdata;
    assign host_out        = r.host;
    assign match_pulse_out = r.match_pulse;
    assign armed_out       = r.armed;
    assign irq             = r.irq;

endmodule

// ### tb/tb.sv
`timescale 1ns/1ps
`include "twde_map.svh"
`define CHK(g, e) \
    begin \
        checked++; \
        if ((g) !== (e)) begin \
            fail_count++; \
            $display("FAIL t=%0t got=%h exp=%h", $time, g, e); \
        end \
    end
module tb
    import twde_pkg::*;
;
    logic        sys_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        clk_en = 1'b1;
    logic [7:0]  bus_addr = 8'h00;
    logic [31:0] bus_wdata = 32'h0;
    logic        bus_wr = 1'b0;
    logic        bus_rd = 1'b0;
    logic        host_reset_req = 1'b0;
    logic [31:0] bus_rdata;
    logic [31:0] v;
    logic        h;
    twde_sut_t   sut;
    twde_host_t  host_out;
    logic        match_pulse_out;
    logic        armed_out;
    logic        irq;
    twde_cfg_t   c;
    int          fail_count = 0;
    int          checked = 0;
    int          n_s = 0;
    int          n_m = 0;
    int          n_d = 0;
    int          d0;
    twde_top dut_u (
        .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
        .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
        .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sut_in(sut),
        .host_reset_req(host_reset_req), .host_out(host_out),
        .match_pulse_out(match_pulse_out), .armed_out(armed_out), .irq(irq)
    );
    twde_sut_model sut_u (.clk(sys_clk), .sut(sut));
    always #20 sys_clk = ~sys_clk;
    always @(posedge sys_clk) begin
        if (host_out.cap_strobe === 1'b1) n_s <= n_s + 1;
        if (match_pulse_out === 1'b1) n_m <= n_m + 1;
        if (host_out.capture_done === 1'b1) n_d <= n_d + 1;
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= 1'b1;
        cyc(1);
        bus_wr <= 1'b0;
        cyc(1);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        bus_addr <= a;
        bus_rd <= 1'b1;
        cyc(1);
        bus_rd <= 1'b0;
        @(negedge sys_clk);
        d = bus_rdata;
        cyc(1);
    endtask
    function automatic logic qok(input logic [1:0] s, input logic q);
        return s == TWDE_Q_X || (s == TWDE_Q_ONE) == q;
    endfunction
    task automatic go(input twde_cfg_t k);
        wr(`TWDE_OFF_ADDR_PAT, {16'h0, k.addr_pat});
        wr(`TWDE_OFF_DATA_PAT, {16'h0, k.data_care, k.data_val});
        wr(`TWDE_OFF_DELAY, {22'h0, k.delay});
        wr(`TWDE_OFF_CTRL, {1'b1, 21'h0, k.byte_view_select, k.q1_sel,
            k.q0_sel, k.amode, k.delay_count_source, k.edge_fall});
        sut_u.idle(k.edge_fall);
        cyc(8);
    endtask
    // One target cycle; m forces the trigger word onto the lines
    task automatic bt(input twde_cfg_t k, input logic m, input logic cq,
                      output logic hit);
        logic [15:0] a;
        logic [7:0]  d;
        logic        aq;
        logic        q;
        int          s0;
        int          m0;
        a = m ? k.addr_pat : 16'($urandom);
        d = 8'($urandom);
        if (m) d = (d & ~k.data_care) | (k.data_val & k.data_care);
        aq = m ? k.q0_sel != TWDE_Q_ZERO : 1'($urandom);
        q = qok(k.q1_sel, cq);
        hit = q && ((d ^ k.data_val) & k.data_care) == 8'h00 &&
            (k.amode == TWDE_AM_OFF || (a == k.addr_pat && qok(k.q0_sel, aq)));
        s0 = n_s;
        m0 = n_m;
        sut_u.beat(a, d, aq, cq);
        cyc(5);
        `CHK(n_s - s0, int'(q))
        `CHK(n_m - m0, int'(hit))
        if (q && k.byte_view_select == TWDE_VIEW_DATA)
            `CHK(host_out.cap_byte, d)
        if (q && k.byte_view_select == TWDE_VIEW_ADDR_LO)
            `CHK(host_out.cap_byte, a[7:0])
        if (q && k.byte_view_select == TWDE_VIEW_ADDR_HI)
            `CHK(host_out.cap_byte, a[15:8])
    endtask
    task automatic report_and_stop;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        cyc(100000);
        fail_count++;
        report_and_stop();
    end
    initial begin
        v = $urandom(97);
        cyc(20);
        nrst <= 1'b1;
        cyc(1);
        wr(`TWDE_OFF_STATUS, 32'h0);
        for (int a = 0; a < 32; a += 4) begin
            rd(8'(a), v);
            `CHK(v, 32'(8'(a) == `TWDE_OFF_STATUS))
        end
        wr(`TWDE_OFF_DELAY, 32'h0000_03FF);
        rd(`TWDE_OFF_DELAY, v);
        `CHK(v[9:0], `TWDE_DELAY_MAX)
        clk_en <= 1'b0;
        wr(`TWDE_OFF_ADDR_PAT, 32'h0000_BEEF);
        clk_en <= 1'b1;
        rd(`TWDE_OFF_ADDR_PAT, v);
        `CHK(v, 32'h0)
        for (int i = 0; i < 40; i++) begin
            c = '0;
            c.edge_fall = 1'($urandom);
            c.amode = twde_amode_t'($urandom_range(1));
            c.q0_sel = twde_qsel_t'($urandom_range(2));
            c.q1_sel = twde_qsel_t'($urandom_range(2));
            c.byte_view_select = twde_view_t'($urandom_range(2));
            c.addr_pat = 16'($urandom);
            c.data_val = 8'($urandom);
            c.data_care = (i < 4) ? 8'hFF : 8'($urandom);
            go(c);
            d0 = n_d;
            bt(c, 1'($urandom), 1'($urandom), h);
            `CHK(armed_out, ~h)
            `CHK(n_d - d0, int'(h))
        end
        for (int s = 0; s < 2; s++) begin
            c = '0;
            c.addr_pat = 16'($urandom);
            c.data_val = 8'($urandom);
            c.data_care = 8'hFF;
            c.delay = 10'h003;
            c.delay_count_source = 1'(s);
            go(c);
            d0 = n_d;
            bt(c, 1'b1, 1'b0, h);
            rd(`TWDE_OFF_STATUS, v);
            `CHK(v, 32'h0003_0002)
            for (int k = 0; k < 3; k++) begin
                if (s == 1) bt(c, 1'b0, 1'b0, h);
                bt(c, 1'(s), 1'b0, h);
                `CHK(n_d - d0, int'(k == 2))
            end
        end
        rd(`TWDE_OFF_IRQ_STAT, v);
        `CHK(v, 32'h3)
        wr(`TWDE_OFF_IRQ_MASK, 32'h2);
        cyc(2);
        `CHK(irq, 1'b1)
        wr(`TWDE_OFF_IRQ_STAT, 32'h3);
        cyc(2);
        `CHK(irq, 1'b0)
        host_reset_req <= 1'b1;
        cyc(6);
        `CHK(armed_out, 1'b1)
        host_reset_req <= 1'b0;
        c = '0;
        c.amode = TWDE_AM_ASYNC;
        c.q0_sel = TWDE_Q_ONE;
        c.addr_pat = 16'($urandom);
        go(c);
        sut_u.hold(c.addr_pat, 1'b1);
        cyc(8);
        `CHK(match_pulse_out, 1'b1)
        sut_u.hold(c.addr_pat, 1'b0);
        cyc(8);
        `CHK(match_pulse_out, 1'b0)
        report_and_stop();
    end
endmodule

// ### tb/twde_properties.sv
`timescale 1ns/1ps
module twde_properties
    import twde_pkg::*;
(
    input wire logic        sys_clk,
    input wire logic        nrst,
    input wire logic        clk_en,
    input wire logic [7:0]  bus_addr,
    input wire logic [31:0] bus_wdata,
    input wire logic        bus_wr,
    input wire logic        bus_rd,
    input wire logic [31:0] bus_rdata,
    input wire twde_sut_t   sut_in,
    input wire logic        host_reset_req,
    input wire twde_host_t  host_out,
    input wire logic        match_pulse_out,
    input wire logic        armed_out,
    input wire logic        irq
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!nrst);
    // Host request needs three edges through its synchroniser
    sequence quiet_s;
        (!host_reset_req && !bus_wr)[*3];
    endsequence
    sequence held_s;
        host_reset_req[*4];
    endsequence
    chk_strobe_single: assert property (
        host_out.cap_strobe |=> !host_out.cap_strobe)
        else $error("capture strobe longer than one cycle");
    chk_strobe_latency: assert property (
        host_out.cap_strobe |-> $past(sut_in.clk, 2) != $past(sut_in.clk, 6))
        else $error("capture strobe without a recent target edge");
    chk_done_single: assert property (
        host_out.capture_done |=> !host_out.capture_done)
        else $error("capture done longer than one cycle");
    chk_done_event: assert property (
        host_out.capture_done |-> host_out.cap_strobe || match_pulse_out)
        else $error("capture done without a counted event");
    chk_done_disarm: assert property (
        host_out.capture_done |-> !armed_out)
        else $error("armed while capture released");
    chk_armed_fall: assert property (
        $fell(armed_out) |-> match_pulse_out)
        else $error("left armed without a trigger word");
    chk_host_rearm: assert property (
        held_s |-> armed_out)
        else $error("host reset did not re-arm");
    chk_disarm_hold: assert property (
        quiet_s ##0 !armed_out |=> !armed_out)
        else $error("re-armed without a request");
endmodule
bind twde_top twde_properties chk_u (
    .sys_clk(sys_clk), .nrst(nrst), .clk_en(clk_en),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
    .bus_rd(bus_rd), .bus_rdata(bus_rdata), .sut_in(sut_in),
    .host_reset_req(host_reset_req), .host_out(host_out),
    .match_pulse_out(match_pulse_out), .armed_out(armed_out), .irq(irq)
);

// ### tb/twde_sut_model.sv
`timescale 1ns/1ps
module twde_sut_model
    import twde_pkg::*;
(
    input  wire logic clk,
    output twde_sut_t sut
);
    initial sut = '0;
    // Idle level is the inactive one, so a mode change makes no active edge
    task automatic idle(input logic f);
        sut.clk <= f;
    endtask
    task automatic hold(input logic [15:0] a, input logic aq);
        sut.addr      <= a;
        sut.addr_qual <= aq;
    endtask
    // Lines move on the inactive edge, stable around the active one;
    // each half period is four system clocks
    task automatic beat(input logic [15:0] a, input logic [7:0] d,
                        input logic aq, input logic cq);
        sut.addr      <= a;
        sut.data      <= d;
        sut.addr_qual <= aq;
        sut.clk_qual  <= cq;
        repeat (4) @(posedge clk);
        sut.clk <= ~sut.clk;
        repeat (4) @(posedge clk);
        sut.clk       <= ~sut.clk;
        sut.addr      <= ~a;
        sut.data      <= ~d;
        sut.addr_qual <= ~aq;
        sut.clk_qual  <= ~cq;
    endtask
endmodule
